// file: core/move_barrier_consts.vh
// constants for the move-to and barrier execution block
`ifndef MOVE_BARRIER_CONSTS_VH
`define MOVE_BARRIER_CONSTS_VH
// primary opcodes
`define OPC_EXT31        6'h1F
// extended opcodes, instruction bits 21:30
`define XO_MSYNC         10'h256
`define XO_MBAR          10'h356
`define XO_MTCRF         10'h090
`define XO_MTDCR         10'h1C3
`define XO_MTMSR         10'h092
`define XO_MTSPR         10'h1D3
// machine state field: problem state bit (little-endian index of big-endian bit 17)
`define MSR_PR_BIT       14
// privileged special register number bit (instruction bit 11 -> number bit 4)
`define SPECIAL_REGISTER_NUMBER_PRIV_BIT    4
// reset values
`define MSR_RESET        32'h00000000
`define CR_RESET         32'h00000000
`endif

// file: core/move_barrier_exec.v
// execution of barrier and move-to-register instructions
`timescale 1ns/10ps
`default_nettype none
`include "move_barrier_consts.vh"

// Overview of operation
// - a synchronize does not complete until all earlier instructions completed, and holds later issue until it completes.
// - a synchronize also waits for all earlier storage accesses to finish before completing.
// - with instruction bit 31 set the first condition field may be left undefined and nothing relies on it.
// - the masked condition move expands each field-mask bit to four bits and merges source and old bits.
// - field-mask bit n selects condition bits 4n to 4n+3 in big-endian numbering.
// - the device control number is split field bits 5:9 above 0:4 and the source is written there.
// - the device control move is privileged and runs only in supervisor state.
// - the machine state move copies the whole source register into the machine state register.
// - the machine state move is privileged and execution synchronizing.
// - the special register number is split field bits 5:9 then 0:4; unassigned numbers are invalid.
// - the special register move is privileged when instruction bit 11 is one.
module move_barrier_exec #(
    parameter [1023:0] SPR_VALID_MAP = {1024{1'b1}}  // assigned special register numbers
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_instr_valid,       // instruction offered for execution
    input  wire [31:0] i_instr,             // instruction word, bit 31 = big-endian bit 0
    input  wire [31:0] i_source_gpr,        // value of the source register
    input  wire        i_older_busy,        // earlier instructions still in flight
    input  wire        i_storage_busy,      // earlier storage accesses outstanding
    output reg         o_instr_ready,       // instruction acknowledge, pulsed together with o_done at completion
    output reg         o_issue_hold,        // later instructions must not start
    output reg         o_done,              // one-cycle completion pulse
    output reg  [31:0] o_condition_register,
    output reg  [31:0] o_machine_state_register,
    output reg         o_dcr_write,         // one-cycle device control write strobe
    output reg  [9:0]  o_device_control_number,
    output reg  [31:0] o_dcr_data,
    output reg         o_spr_write,         // one-cycle special register write strobe
    output reg  [9:0]  o_special_register_number,
    output reg  [31:0] o_spr_data,
    output reg         o_priv_exception,    // privileged-instruction program exception
    output reg         o_invalid_form       // illegal special register number
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SYNC = 1'b1;

    // field decode; bit 31 (record) is ignored so condition field 0 is simply left as is
    wire [5:0] opcode     = i_instr[31:26];
    wire [9:0] xo         = i_instr[10:1];
    wire [7:0] field_mask = i_instr[19:12];
    wire [9:0] split_field = i_instr[20:11];
    // swap halves: big-endian bits 5:9 of the split field become the high half
    wire [9:0] swapped_number = {split_field[4:0], split_field[9:5]};
    wire       is31      = (opcode == `OPC_EXT31);
    wire       is_sync   = is31 && ((xo == `XO_MSYNC) || (xo == `XO_MBAR));
    wire       is_mtcrf  = is31 && (xo == `XO_MTCRF);
    wire       is_mtdcr  = is31 && (xo == `XO_MTDCR);
    wire       is_mtmsr  = is31 && (xo == `XO_MTMSR);
    wire       is_mtspr  = is31 && (xo == `XO_MTSPR);
    wire       user_mode = o_machine_state_register[`MSR_PR_BIT];
    wire       spr_priv  = swapped_number[`SPECIAL_REGISTER_NUMBER_PRIV_BIT];
    wire       needs_priv = is_mtdcr || is_mtmsr || (is_mtspr && spr_priv);
    wire       priv_fault = needs_priv && user_mode;
    wire       needs_sync = is_sync || (is_mtmsr && !priv_fault);

    // mask expansion, one nibble per field-mask bit
    wire [31:0] cr_mask;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_mask
            // big-endian field g sits at little-endian bits 31-4g down to 28-4g
            assign cr_mask[31-4*g -: 4] = {4{field_mask[7-g]}};
        end
    endgenerate

    // sequencer state and the pending synchronizing op
    reg        state_q;
    reg        state_d;
    reg        sync_msr_q;      // pending synchronizing op is a machine state move
    reg        sync_msr_d;
    reg [31:0] sync_data_q;     // source value held for a deferred machine state write
    reg [31:0] sync_data_d;

    // next values of the registered outputs
    reg        ready_d;
    reg        hold_d;
    reg        done_d;
    reg [31:0] cr_d;
    reg [31:0] msr_d;
    reg        dcr_write_d;
    reg [9:0]  dcr_number_d;
    reg [31:0] dcr_data_d;
    reg        spr_write_d;
    reg [9:0]  spr_number_d;
    reg [31:0] spr_data_d;
    reg        priv_exc_d;
    reg        invalid_d;

    // drain and acceptance conditions
    reg        sync_ready;
    reg        take;

    // drain condition for synchronizing ops
    always @* begin
        sync_ready = !i_older_busy && !i_storage_busy;
    end

    // the master may keep its request up through the edge that samples the acknowledge,
    // so that edge must not take the same instruction a second time
    always @* begin
        take = i_instr_valid && !o_instr_ready && (state_q == ST_IDLE);
    end

    // next-state and result logic
    always @* begin
        // pulses drop by default, held values keep their register contents
        state_d      = state_q;
        sync_msr_d   = sync_msr_q;
        sync_data_d  = sync_data_q;
        ready_d      = 1'b0;
        hold_d       = o_issue_hold;
        done_d       = 1'b0;
        cr_d         = o_condition_register;
        msr_d        = o_machine_state_register;
        dcr_write_d  = 1'b0;
        dcr_number_d = o_device_control_number;
        dcr_data_d   = o_dcr_data;
        spr_write_d  = 1'b0;
        spr_number_d = o_special_register_number;
        spr_data_d   = o_spr_data;
        priv_exc_d   = 1'b0;
        invalid_d    = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (take && needs_sync) begin
                    // hold later issue and wait for drain
                    state_d     = ST_SYNC;
                    sync_msr_d  = is_mtmsr;
                    sync_data_d = i_source_gpr;
                    hold_d      = 1'b1;
                end else if (take) begin
                    ready_d = 1'b1;
                    done_d  = 1'b1;
                    if (priv_fault) begin
                        priv_exc_d = 1'b1;
                    end else if (is_mtcrf) begin
                        cr_d = (i_source_gpr & cr_mask) | (o_condition_register & ~cr_mask);
                    end else if (is_mtdcr) begin
                        // number forwarded untouched to chip-level space
                        dcr_write_d  = 1'b1;
                        dcr_number_d = swapped_number;
                        dcr_data_d   = i_source_gpr;
                    end else if (is_mtspr) begin
                        if (SPR_VALID_MAP[swapped_number]) begin
                            spr_write_d  = 1'b1;
                            spr_number_d = swapped_number;
                            spr_data_d   = i_source_gpr;
                        end else begin
                            invalid_d = 1'b1;
                        end
                    end
                end
            end
            ST_SYNC: begin
                if (sync_ready) begin
                    state_d = ST_IDLE;
                    hold_d  = 1'b0;
                    ready_d = 1'b1;
                    done_d  = 1'b1;
                    if (sync_msr_q) begin
                        msr_d = sync_data_q;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                hold_d  = 1'b0;
            end
        endcase
    end

    // state and output registers; every output leaves straight from here
    always @(posedge i_clk) begin
        if (i_rst) begin
            // supervisor state, nothing pending
            state_q                   <= ST_IDLE;
            sync_msr_q                <= 1'b0;
            sync_data_q               <= 32'h00000000;
            o_instr_ready             <= 1'b0;
            o_issue_hold              <= 1'b0;
            o_done                    <= 1'b0;
            o_condition_register      <= `CR_RESET;
            o_machine_state_register  <= `MSR_RESET;
            o_dcr_write               <= 1'b0;
            o_device_control_number   <= 10'h000;
            o_dcr_data                <= 32'h00000000;
            o_spr_write               <= 1'b0;
            o_special_register_number <= 10'h000;
            o_spr_data                <= 32'h00000000;
            o_priv_exception          <= 1'b0;
            o_invalid_form            <= 1'b0;
        end else begin
            // load the next values
            state_q                   <= state_d;
            sync_msr_q                <= sync_msr_d;
            sync_data_q               <= sync_data_d;
            o_instr_ready             <= ready_d;
            o_issue_hold              <= hold_d;
            o_done                    <= done_d;
            o_condition_register      <= cr_d;
            o_machine_state_register  <= msr_d;
            o_dcr_write               <= dcr_write_d;
            o_device_control_number   <= dcr_number_d;
            o_dcr_data                <= dcr_data_d;
            o_spr_write               <= spr_write_d;
            o_special_register_number <= spr_number_d;
            o_spr_data                <= spr_data_d;
            o_priv_exception          <= priv_exc_d;
            o_invalid_form            <= invalid_d;
        end
    end

endmodule // move_barrier_exec
`default_nettype wire

// file: testbench/far_side_model.sv
// earlier instructions and storage accesses draining over time
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
    input  wire logic       i_clk,
    input  wire logic       i_load,
    input  wire logic [3:0] i_old_cycles,
    input  wire logic [3:0] i_sto_cycles,
    output var  logic       o_older_busy,
    output var  logic       o_storage_busy
);
    logic [3:0] old_q = 4'h0;
    logic [3:0] sto_q = 4'h0;
    // outstanding work retires one step a cycle
    always @(posedge i_clk) begin
        old_q <= i_load ? i_old_cycles : old_q - {3'h0, old_q != 4'h0};
        sto_q <= i_load ? i_sto_cycles : sto_q - {3'h0, sto_q != 4'h0};
    end
    assign o_older_busy   = old_q != 4'h0;
    assign o_storage_busy = sto_q != 4'h0;
endmodule // far_side_model
`default_nettype wire

// file: testbench/move_barrier_asserts.sv
// port assertions for the move-to and barrier execution block
`timescale 1ns/10ps
`default_nettype none
`include "move_barrier_consts.vh"
module move_barrier_asserts (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_older_busy,
    input wire logic        i_storage_busy,
    input wire logic        o_instr_ready,
    input wire logic        o_issue_hold,
    input wire logic        o_done,
    input wire logic [31:0] o_condition_register,
    input wire logic [31:0] o_machine_state_register,
    input wire logic        o_dcr_write,
    input wire logic        o_spr_write,
    input wire logic [9:0]  o_special_register_number,
    input wire logic        o_priv_exception
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // sync ops wait for earlier work, then release issue with completion
    property p_hold_older; o_issue_hold && i_older_busy |=> !o_done; endproperty
    a_hold_older: assert property (p_hold_older) else $error("done while older work busy");
    property p_hold_storage; o_issue_hold && i_storage_busy |=> !o_done; endproperty
    a_hold_storage: assert property (p_hold_storage) else $error("done while storage busy");
    property p_sync_release; o_issue_hold && !i_older_busy && !i_storage_busy |=> o_done && !o_issue_hold; endproperty
    a_sync_release: assert property (p_sync_release) else $error("sync op did not finish");
    // privileged writes only from supervisor state
    property p_dcr_priv; o_dcr_write |-> !o_machine_state_register[`MSR_PR_BIT]; endproperty
    a_dcr_priv: assert property (p_dcr_priv) else $error("dcr write in user state");
    property p_spr_priv; o_spr_write && o_special_register_number[4] |-> !o_machine_state_register[`MSR_PR_BIT]; endproperty
    a_spr_priv: assert property (p_spr_priv) else $error("privileged spr write in user state");
    property p_exc_no_write; o_priv_exception |-> o_done && !o_dcr_write && !o_spr_write; endproperty
    a_exc_no_write: assert property (p_exc_no_write) else $error("write beside exception");
    // state changes only at completion of the right kind of op
    property p_msr_change; !$stable(o_machine_state_register) && !$past(i_rst) |-> o_done && $past(o_issue_hold)
        && !$past(o_machine_state_register[`MSR_PR_BIT]); endproperty
    a_msr_change: assert property (p_msr_change) else $error("msr changed out of sync op");
    property p_cr_change; !$stable(o_condition_register[27:0]) && !$past(i_rst)
        |-> o_done && !$past(o_issue_hold); endproperty
    a_cr_change: assert property (p_cr_change) else $error("cr changed outside a field move");
    // acknowledge pairs with completion and a held request is not taken twice
    property p_no_retake; o_instr_ready |-> o_done ##1 !o_instr_ready && !o_done; endproperty
    a_no_retake: assert property (p_no_retake) else $error("instruction taken twice");
    c_sync: cover property (o_issue_hold ##1 o_done);
    c_exc: cover property (o_priv_exception);
    c_dcr: cover property (o_dcr_write);
    c_spr: cover property (o_spr_write);
endmodule // move_barrier_asserts
bind move_barrier_exec move_barrier_asserts chk_u (.i_clk, .i_rst, .i_older_busy, .i_storage_busy, .o_issue_hold,
    .o_instr_ready, .o_done, .o_condition_register, .o_machine_state_register, .o_dcr_write, .o_spr_write,
    .o_special_register_number, .o_priv_exception);
`default_nettype wire

// file: testbench/move_to_reg_and_barrier_exec_bench.sv
// self-checking bench for the move-to and barrier execution block
`timescale 1ns/10ps
`default_nettype none
`include "move_barrier_consts.vh"
module move_to_reg_and_barrier_exec_bench;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0, lat_load = 1'b0, user, priv, bad, sy;
    logic [31:0] i_instr = 32'h0, i_source_gpr = 32'h0, cr = 32'h0, machine_state_register = 32'h0, care = 32'hFFFFFFFF, ins, src;
    logic [3:0]  lat_old = 4'h0, lat_sto = 4'h0, flags;
    logic [9:0]  xo, xo_tab [6] = '{`XO_MSYNC, `XO_MBAR, `XO_MTCRF, `XO_MTDCR, `XO_MTMSR, `XO_MTSPR};
    wire         i_older_busy, i_storage_busy, o_instr_ready, o_issue_hold, o_done, o_dcr_write, o_spr_write;
    wire         o_priv_exception, o_invalid_form;
    wire  [31:0] o_condition_register, o_machine_state_register, o_dcr_data, o_spr_data;
    wire  [9:0]  o_device_control_number, o_special_register_number;
    int          errors = 0, comparisons = 0, cycles = 0, n, hn, lo, ls;
    move_barrier_exec #(.SPR_VALID_MAP(~(1024'h1 << 5))) dut_u (.i_clk, .i_rst, .i_instr_valid, .i_instr,
        .i_source_gpr, .i_older_busy, .i_storage_busy, .o_instr_ready, .o_issue_hold, .o_done, .o_condition_register,
        .o_machine_state_register, .o_dcr_write, .o_device_control_number, .o_dcr_data, .o_spr_write,
        .o_special_register_number, .o_spr_data, .o_priv_exception, .o_invalid_form);
    far_side_model far_u (.i_clk, .i_load(lat_load), .i_old_cycles(lat_old), .i_sto_cycles(lat_sto),
        .o_older_busy(i_older_busy), .o_storage_busy(i_storage_busy));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // offer one instruction, hold it until completion, count cycles
    task automatic run_op;
        n = 0;
        hn = 0;
        @(posedge i_clk);
        i_instr <= ins;
        i_source_gpr <= src;
        i_instr_valid <= 1'b1;
        lat_load <= 1'b1;
        lat_old <= lo[3:0];
        lat_sto <= ls[3:0];
        do begin
            @(posedge i_clk);
            lat_load <= 1'b0;
            n++;
            if (o_issue_hold === 1'b1) hn++;
        end while (o_instr_ready !== 1'b1 && n < 40);
        i_instr_valid <= 1'b0;
    endtask
    // clock and hang limit
    initial forever #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            results;
        end
    end
    // random instruction stream against the behavioural model
    initial begin
        n = $urandom(86637);
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int t = 0; t < 400; t++) begin
            if (machine_state_register[`MSR_PR_BIT] && t % 5 == 0) begin
                @(posedge i_clk);
                i_rst <= 1'b1;
                @(posedge i_clk);
                i_rst <= 1'b0;
                machine_state_register = `MSR_RESET;
                cr = `CR_RESET;
                care = 32'hFFFFFFFF;
            end
            ins = $urandom;
            src = $urandom;
            lo = $urandom % 8;
            ls = $urandom % 8;
            xo = xo_tab[t % 6];
            ins[31:26] = `OPC_EXT31;
            ins[10:1] = xo;
            if (t % 12 == 11) ins[20:11] = 10'h0A0;
            user = machine_state_register[`MSR_PR_BIT];
            priv = xo == `XO_MTDCR || xo == `XO_MTMSR || (xo == `XO_MTSPR && ins[20]);
            bad = xo == `XO_MTSPR && ins[20:11] == 10'h0A0;
            sy = xo == `XO_MSYNC || xo == `XO_MBAR || (xo == `XO_MTMSR && !user);
            flags = {xo == `XO_MTDCR && !(priv && user), xo == `XO_MTSPR && !(priv && user) && !bad, priv && user, bad};
            run_op;
            if (xo == `XO_MTCRF) for (int k = 0; k < 8; k++) if (ins[12 + k]) cr[4 * k +: 4] = src[4 * k +: 4];
            if (xo == `XO_MTMSR && !user) machine_state_register = src;
            if (xo == `XO_MTCRF && ins[19]) care[31:28] = 4'hF;
            if (ins[0]) care[31:28] = 4'h0;
            chk(n, sy ? 3 + (lo > ls ? lo : ls) : 2);
            chk(hn, sy ? 1 + (lo > ls ? lo : ls) : 0);
            chk(o_done, 1'b1);
            chk({o_dcr_write, o_spr_write, o_priv_exception, o_invalid_form}, flags);
            chk(o_condition_register & care, cr & care);
            chk(o_machine_state_register, machine_state_register);
            if (flags[3]) chk({o_device_control_number, o_dcr_data}, {ins[15:11], ins[20:16], src});
            if (flags[2]) chk({o_special_register_number, o_spr_data}, {ins[15:11], ins[20:16], src});
            $display("op %0d xo %h done", t, xo);
        end
        results;
    end
endmodule // move_to_reg_and_barrier_exec_bench
`default_nettype wire
